// ### design/ofr_pkg.sv
package ofr_pkg;

  // ----------------------------------------------------------------
  // Frame geometry and patterns
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 256;
  localparam int FRAME_RATE_HZ = 8000;
  localparam int OH_BITS = 8;
  localparam int MF_FRAMES = 16;
  localparam int SMF_FRAMES = 8;
  localparam int SMF_BITS = FRAME_BITS * SMF_FRAMES;
  localparam logic [6:0] FAS_PATTERN = 7'h1b;
  localparam logic [5:0] MFAS_PATTERN = 6'h0b;
  localparam logic [3:0] CRC4_POLY = 4'h3;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STAT = 6'h04;
  localparam logic [5:0] REG_IRQ = 6'h08;
  localparam logic [5:0] REG_MASK = 6'h0c;
  localparam logic [5:0] REG_RXOH = 6'h10;
  localparam logic [5:0] REG_ERRCNT = 6'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_CRC_EN = 0;
  localparam int CTL_CRC_AUTO = 1;
  localparam int CTL_ALARM = 2;
  localparam int CTL_ALARM_AUTO = 3;
  localparam int CTL_SI = 4;
  localparam int CTL_SPARE = 8;
  localparam int CTL_SSM_SEL = 16;
  localparam int CTL_SSM = 20;
  localparam int ST_FRAME_LOCK = 0;
  localparam int ST_MF_LOCK = 1;
  localparam int ST_CRC_ON = 2;
  localparam int ST_FALLBACK = 3;
  localparam int RXOH_SPARE = 0;
  localparam int RXOH_ALARM = 8;
  localparam int IRQ_LOCK_LOST = 0;
  localparam int IRQ_LOCK_GAIN = 1;
  localparam int IRQ_SMF_ERR = 2;
  localparam int IRQ_MF_GAIN = 3;
  localparam int IRQ_W = 4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_1f18;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
  localparam int FA_LOSS_ERRS = 3;
  localparam int AUTO_SEARCH_FRAMES = 800;

  typedef struct packed {
    logic crc_en;
    logic crc_auto;
    logic alarm;
    logic alarm_auto;
    logic si;
    logic [4:0] spare;
    logic [2:0] ssm_sel;
    logic [3:0] sync_status_message;
  } ofr_cfg_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_LOCK = 2'b10
  } ofr_rx_st_t;

endpackage

// ### design/ofr_crc.sv
`timescale 1ns/100ps
module ofr_crc import ofr_pkg::*; #(
  parameter int W = 4,
  parameter logic [W-1:0] POLY = CRC4_POLY
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic clr,
  input wire logic din,
  output logic [W-1:0] rem_nxt
);
  logic [W-1:0] rem_r;
  logic fb;

  if (W < 2) begin : g_bad_w
    $error("ofr_crc: W must be at least 2");
  end

  // Divide by POLY after shifting the message up by W bits
  assign fb = din ^ rem_r[W-1];
  assign rem_nxt = {rem_r[W-2:0], 1'b0} ^ (fb ? POLY : '0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= '0;
    end else if (clr) begin
      rem_r <= '0;
    end else if (en) begin
      rem_r <= rem_nxt;
    end
  end
endmodule

// ### design/ofr_framer.sv
`timescale 1ns/100ps
// Contract
// - A frame has 256 bit positions and frames repeat 8000 times a second.
// - Frames alternate, alignment frames carry 0011011 in bits 2 to 8.
// - Bit 2 of every non-alignment frame is sent as 1.
// - Bit 3 of non-alignment frames is 0 normally and 1 in alarm.
// - Bit 1 is the international bit, held at its set value (1) if unused.
// - Unused spare bits 4 to 8 of non-alignment frames are sent as 1.
// - A modified spare_link_bit is covered by the check bits sent.
// - Any one spare bit may carry the sync_status_message.
// - With CRC-4 on, bit 1 carries the CRC-4 procedure.
// - A manual setting turns CRC-4 off and returns bit 1 to its fixed 1.
// - Optionally CRC-4 use is chosen by a multiframe alignment search.
// - CRC-4 multiframes are 16 frames of two 2048-bit sub-multiframes.
// - Non-alignment bit 1 carries 001011 then two error indication bits.
// - Error bits are 0 until aligned, then one 0 per errored block.
module ofr_framer import ofr_pkg::*; #(
  parameter int AUTO_FRAMES = AUTO_SEARCH_FRAMES,
  parameter int FA_ERRS = FA_LOSS_ERRS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic line_clk,
  input wire logic line_rx,
  output logic line_tx,
  input wire logic pay_tx_bit,
  output logic pay_tx_take,
  output logic pay_rx_bit,
  output logic pay_rx_valid,
  output logic irq
);
  if (AUTO_FRAMES < 1 || AUTO_FRAMES > 65535 || FA_ERRS < 1 ||
      FA_ERRS > 7) begin : g_bad_par
    $error("ofr_framer: parameter out of range");
  end

  // ----------------------------------------------------------------
  // Line pin synchronisers and edge find
  // ----------------------------------------------------------------
  logic [1:0] sync_r [2];
  logic lc_d_r;
  logic lc_rise;
  logic rx_s;

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        sync_r[i] <= 2'h0;
      end else begin
        sync_r[i] <= {sync_r[i][0], (i == 0) ? line_clk : line_rx};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lc_d_r <= 1'b0;
    end else begin
      lc_d_r <= sync_r[0][1];
    end
  end

  assign lc_rise = sync_r[0][1] & ~lc_d_r;
  assign rx_s = sync_r[1][1];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_go;
  ofr_cfg_t cfg_r;
  ofr_cfg_t cfg_f_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_ev;
  logic irq_r;
  logic [15:0] err_cnt_r;
  logic fallback_r;
  logic crc_on;
  ofr_rx_st_t rx_st_r;
  logic mf_lock_r;
  logic [4:0] rx_spare_r;
  logic rx_alarm_r;

  // One wait cycle, then the answer stands for the edge it is taken on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if ((avs_read | avs_write) & waitreq_r) begin
      waitreq_r <= 1'b0;
      rdata_r <= avs_read ? rdata_nxt : 32'h0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  assign wr_go = avs_write & ~waitreq_r;

  always_comb begin
    rdata_nxt = 32'h0;
    unique case (avs_address)
      REG_CTRL: begin
        rdata_nxt[CTL_CRC_EN] = cfg_r.crc_en;
        rdata_nxt[CTL_CRC_AUTO] = cfg_r.crc_auto;
        rdata_nxt[CTL_ALARM] = cfg_r.alarm;
        rdata_nxt[CTL_ALARM_AUTO] = cfg_r.alarm_auto;
        rdata_nxt[CTL_SI] = cfg_r.si;
        rdata_nxt[CTL_SPARE +: 5] = cfg_r.spare;
        rdata_nxt[CTL_SSM_SEL +: 3] = cfg_r.ssm_sel;
        rdata_nxt[CTL_SSM +: 4] = cfg_r.sync_status_message;
      end
      REG_STAT: begin
        rdata_nxt[ST_FRAME_LOCK] = (rx_st_r == RX_LOCK);
        rdata_nxt[ST_MF_LOCK] = mf_lock_r;
        rdata_nxt[ST_CRC_ON] = crc_on;
        rdata_nxt[ST_FALLBACK] = fallback_r;
      end
      REG_IRQ: rdata_nxt[IRQ_W-1:0] = irq_st_r;
      REG_MASK: rdata_nxt[IRQ_W-1:0] = irq_mask_r;
      REG_RXOH: begin
        rdata_nxt[RXOH_SPARE +: 5] = rx_spare_r;
        rdata_nxt[RXOH_ALARM] = rx_alarm_r;
      end
      REG_ERRCNT: rdata_nxt[15:0] = err_cnt_r;
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '{CTRL_RST[CTL_CRC_EN], CTRL_RST[CTL_CRC_AUTO],
                 CTRL_RST[CTL_ALARM], CTRL_RST[CTL_ALARM_AUTO],
                 CTRL_RST[CTL_SI], CTRL_RST[CTL_SPARE +: 5],
                 CTRL_RST[CTL_SSM_SEL +: 3], CTRL_RST[CTL_SSM +: 4]};
      irq_mask_r <= MASK_RST;
    end else if (wr_go) begin
      if (avs_address == REG_CTRL) begin
        cfg_r <= '{avs_writedata[CTL_CRC_EN], avs_writedata[CTL_CRC_AUTO],
                   avs_writedata[CTL_ALARM], avs_writedata[CTL_ALARM_AUTO],
                   avs_writedata[CTL_SI], avs_writedata[CTL_SPARE +: 5],
                   avs_writedata[CTL_SSM_SEL +: 3],
                   avs_writedata[CTL_SSM +: 4]};
      end
      if (avs_address == REG_MASK) begin
        irq_mask_r <= avs_writedata[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event beats a same-cycle write of one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~((wr_go && avs_address == REG_IRQ) ?
                   avs_writedata[IRQ_W-1:0] : '0)) | irq_ev;
      irq_r <= |(irq_st_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Transmit overhead
  // ----------------------------------------------------------------
  logic [7:0] tx_pos_r;
  logic [3:0] tx_frame_r;
  logic [3:0] tx_hold_r;
  logic [3:0] tx_rem_nxt;
  logic [1:0] e_pend_r;
  logic tx_r;
  logic take_r;
  logic tx_val;
  logic tx_crcin;
  logic tx_smf_end;
  logic e_use;
  logic e_dec;
  logic e_inc;
  logic alarm;
  logic [2:0] sp_idx;

  assign crc_on = cfg_f_r.crc_en & ~(cfg_f_r.crc_auto & fallback_r);
  assign alarm = cfg_f_r.alarm | (cfg_f_r.alarm_auto & (rx_st_r != RX_LOCK));
  assign e_use = (rx_st_r == RX_LOCK) & mf_lock_r;
  assign sp_idx = tx_pos_r[2:0] - 3'h3;
  assign tx_smf_end = (tx_pos_r == 8'hff) & (tx_frame_r[2:0] == 3'h7);

  always_comb begin
    tx_val = pay_tx_bit;
    tx_crcin = pay_tx_bit;
    e_dec = 1'b0;
    if (tx_pos_r < 8'(OH_BITS)) begin
      if (!tx_frame_r[0]) begin
        if (tx_pos_r == 8'h0) begin
          // C bits go out as the previous block's remainder
          tx_val = crc_on ? tx_hold_r[~tx_frame_r[2:1]] : cfg_f_r.si;
          tx_crcin = crc_on ? 1'b0 : cfg_f_r.si;
        end else begin
          tx_val = FAS_PATTERN[3'h7 - tx_pos_r[2:0]];
          tx_crcin = tx_val;
        end
      end else begin
        unique case (tx_pos_r[2:0])
          3'h0: begin
            if (!crc_on) begin
              tx_val = cfg_f_r.si;
            end else if (tx_frame_r[3:1] < 3'h6) begin
              tx_val = MFAS_PATTERN[3'h5 - tx_frame_r[3:1]];
            end else begin
              tx_val = e_use & (e_pend_r == 2'h0);
              e_dec = e_use & (e_pend_r != 2'h0);
            end
          end
          3'h1: tx_val = 1'b1;
          3'h2: tx_val = alarm;
          default: begin
            tx_val = cfg_f_r.spare[sp_idx];
            if (cfg_f_r.ssm_sel == sp_idx + 3'h1) begin
              tx_val = cfg_f_r.sync_status_message[~tx_frame_r[2:1]];
            end
          end
        endcase
        tx_crcin = tx_val;
      end
    end
  end

  // Check bits see the bits as sent, so local spare_link_bit edits are
  // covered end to end
  ofr_crc #(.W(4), .POLY(CRC4_POLY)) u_tx_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(lc_rise),
    .clr(lc_rise & tx_smf_end),
    .din(tx_crcin),
    .rem_nxt(tx_rem_nxt)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pos_r <= 8'h0;
      tx_frame_r <= 4'h0;
      tx_hold_r <= 4'h0;
      tx_r <= 1'b1;
      take_r <= 1'b0;
      cfg_f_r <= '{CTRL_RST[CTL_CRC_EN], CTRL_RST[CTL_CRC_AUTO],
                   CTRL_RST[CTL_ALARM], CTRL_RST[CTL_ALARM_AUTO],
                   CTRL_RST[CTL_SI], CTRL_RST[CTL_SPARE +: 5],
                   CTRL_RST[CTL_SSM_SEL +: 3], CTRL_RST[CTL_SSM +: 4]};
    end else begin
      take_r <= lc_rise & (tx_pos_r >= 8'(OH_BITS));
      if (lc_rise) begin
        tx_r <= tx_val;
        tx_pos_r <= tx_pos_r + 8'h1;
        if (tx_pos_r == 8'hff) begin
          tx_frame_r <= tx_frame_r + 4'h1;
          cfg_f_r <= cfg_r;
        end
        if (tx_smf_end) begin
          tx_hold_r <= tx_rem_nxt;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive alignment and check
  // ----------------------------------------------------------------
  logic [6:0] rx_sh_r;
  logic [6:0] rx_win;
  logic [7:0] rx_pos_r;
  logic [3:0] rx_frame_r;
  logic [2:0] fa_err_r;
  logic [5:0] mf_sh_r;
  logic [3:0] rx_c_r;
  logic [3:0] rx_calc_r;
  logic [3:0] rx_rem_nxt;
  logic calc_ok_r;
  logic smf_seen_r;
  logic [15:0] auto_cnt_r;
  logic pay_bit_r;
  logic pay_vld_r;
  logic rx_smf_end;
  logic rx_step;
  logic fa_bad;
  logic lock_gain;
  logic lock_lost;
  logic mf_gain;
  logic smf_err;

  assign rx_win = {rx_sh_r[5:0], rx_s};
  assign rx_step = lc_rise & (rx_st_r == RX_LOCK);
  assign rx_smf_end = (rx_pos_r == 8'hff) & (rx_frame_r[2:0] == 3'h7);
  assign fa_bad = rx_frame_r[0] ? (rx_pos_r == 8'h1) & ~rx_s
                                : (rx_pos_r == 8'h7) & (rx_win != FAS_PATTERN);
  assign lock_gain = lc_rise & (rx_st_r == RX_HUNT) & (rx_win == FAS_PATTERN);
  assign lock_lost = rx_step & fa_bad & (fa_err_r == 3'(FA_ERRS - 1));
  assign mf_gain = rx_step & rx_frame_r[0] & (rx_pos_r == 8'h0) & ~mf_lock_r &
                   (cfg_f_r.crc_en | cfg_f_r.crc_auto) &
                   ({mf_sh_r[4:0], rx_s} == MFAS_PATTERN);
  assign smf_err = rx_step & rx_smf_end & calc_ok_r & (rx_c_r != rx_calc_r);
  assign irq_ev = {mf_gain, smf_err, lock_gain, lock_lost};

  ofr_crc #(.W(4), .POLY(CRC4_POLY)) u_rx_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(rx_step),
    .clr(~mf_lock_r | (rx_step & rx_smf_end)),
    .din(rx_s & ~(~rx_frame_r[0] & (rx_pos_r == 8'h0))),
    .rem_nxt(rx_rem_nxt)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_r <= 7'h0;
    end else if (lc_rise) begin
      rx_sh_r <= rx_win;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= RX_HUNT;
      rx_pos_r <= 8'h0;
      rx_frame_r <= 4'h0;
      fa_err_r <= 3'h0;
      mf_sh_r <= 6'h0;
      mf_lock_r <= 1'b0;
    end else if (lc_rise) begin
      unique case (rx_st_r)
        RX_HUNT: begin
          if (lock_gain) begin
            rx_st_r <= RX_LOCK;
            rx_pos_r <= 8'(OH_BITS);
            rx_frame_r <= 4'h0;
            fa_err_r <= 3'h0;
          end
        end
        RX_LOCK: begin
          rx_pos_r <= rx_pos_r + 8'h1;
          if (rx_pos_r == 8'hff) begin
            rx_frame_r <= rx_frame_r + 4'h1;
          end
          if (fa_bad) begin
            fa_err_r <= fa_err_r + 3'h1;
          end else if (~rx_frame_r[0] & (rx_pos_r == 8'h7)) begin
            fa_err_r <= 3'h0;
          end
          if (rx_frame_r[0] & (rx_pos_r == 8'h0)) begin
            mf_sh_r <= {mf_sh_r[4:0], rx_s};
          end
          if (mf_gain) begin
            mf_lock_r <= 1'b1;
            rx_frame_r <= 4'hb;
          end
          if (lock_lost) begin
            rx_st_r <= RX_HUNT;
            mf_lock_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Block checks start at the end of the second full block after multiframe lock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_c_r <= 4'h0;
      rx_calc_r <= 4'h0;
      calc_ok_r <= 1'b0;
      smf_seen_r <= 1'b0;
      err_cnt_r <= 16'h0;
      rx_spare_r <= 5'h1f;
      rx_alarm_r <= 1'b0;
      pay_bit_r <= 1'b0;
      pay_vld_r <= 1'b0;
    end else begin
      pay_vld_r <= rx_step & (rx_pos_r >= 8'(OH_BITS));
      if (~mf_lock_r) begin
        calc_ok_r <= 1'b0;
        smf_seen_r <= 1'b0;
      end
      if (rx_step) begin
        pay_bit_r <= rx_s;
        if (~rx_frame_r[0] & (rx_pos_r == 8'h0)) begin
          rx_c_r <= {rx_c_r[2:0], rx_s};
        end
        if (rx_frame_r[0] & (rx_pos_r == 8'h2)) begin
          rx_alarm_r <= rx_s;
        end
        if (rx_frame_r[0] & (rx_pos_r > 8'h2) & (rx_pos_r < 8'(OH_BITS))) begin
          rx_spare_r[rx_pos_r[2:0] - 3'h3] <= rx_s;
        end
        if (rx_smf_end & mf_lock_r) begin
          rx_calc_r <= rx_rem_nxt;
          smf_seen_r <= 1'b1;
          calc_ok_r <= smf_seen_r;
        end
        if (smf_err && err_cnt_r != 16'hffff) begin
          err_cnt_r <= err_cnt_r + 16'h1;
        end
      end
    end
  end

  // Errored blocks owed to the far end, spent one per E bit
  assign e_inc = smf_err & e_use;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      e_pend_r <= 2'h0;
    end else if (~e_use) begin
      e_pend_r <= 2'h0;
    end else begin
      if (e_inc & ~(lc_rise & e_dec) & (e_pend_r != 2'h3)) begin
        e_pend_r <= e_pend_r + 2'h1;
      end else if (~e_inc & lc_rise & e_dec) begin
        e_pend_r <= e_pend_r - 2'h1;
      end
    end
  end

  // Automatic choice: no multiframe found in time means a plain far end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_cnt_r <= 16'h0;
      fallback_r <= 1'b0;
    end else if (~cfg_f_r.crc_auto | (rx_st_r != RX_LOCK) | mf_lock_r) begin
      auto_cnt_r <= 16'h0;
      fallback_r <= fallback_r & cfg_f_r.crc_auto & ~mf_lock_r;
    end else if (rx_step & (rx_pos_r == 8'hff) & ~fallback_r) begin
      auto_cnt_r <= auto_cnt_r + 16'h1;
      if (auto_cnt_r == 16'(AUTO_FRAMES - 1)) begin
        fallback_r <= 1'b1;
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = waitreq_r;
  assign line_tx = tx_r;
  assign pay_tx_take = take_r;
  assign pay_rx_bit = pay_bit_r;
  assign pay_rx_valid = pay_vld_r;
  assign irq = irq_r;
endmodule

// ### sim/ofr_framer_asserts.sv
`timescale 1ns/100ps
module ofr_framer_asserts import ofr_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic line_clk,
  input wire logic line_tx,
  input wire logic pay_tx_take,
  input wire logic pay_rx_valid,
  input wire logic irq
);
  // ----
  // Cycles since line clock rose
  // ----
  logic lc_q_r;
  logic [3:0] since_rise_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lc_q_r <= 1'b0;
      since_rise_r <= 4'hf;
    end else begin
      lc_q_r <= line_clk;
      if (line_clk && !lc_q_r) since_rise_r <= 4'h0;
      else if (since_rise_r != 4'hf) since_rise_r <= since_rise_r + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_granted;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_BUS_ANSWER: assert property (s_request |=> s_granted)
    else $error("bus request not answered in one cycle");
  AST_BUS_NO_SPURIOUS: assert property (!avs_waitrequest |->
    $past(avs_read || avs_write)) else $error("answer without request");
  AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest &&
    avs_address >= 6'h18 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MASK_OFF_IRQ: assert property (avs_write && !avs_waitrequest &&
    avs_address == REG_MASK && avs_writedata[IRQ_W-1:0] == 4'h0
    |-> ##[1:3] !irq) else $error("irq high with all masked");
  AST_TX_AFTER_EDGE: assert property ($changed(line_tx) |->
    since_rise_r <= 4'h6) else $error("line bit moved off line edge");
  AST_TAKE_PULSE: assert property (pay_tx_take |=> !pay_tx_take)
    else $error("payload take longer than one cycle");
  AST_TAKE_AFTER_EDGE: assert property (pay_tx_take |->
    since_rise_r inside {[4'h1:4'h6]}) else $error("take off line edge");
  AST_RX_VALID_PULSE: assert property (pay_rx_valid |=> !pay_rx_valid)
    else $error("rx valid longer than one cycle");
  AST_RX_AFTER_EDGE: assert property (pay_rx_valid |->
    since_rise_r inside {[4'h1:4'h6]}) else $error("rx valid off edge");
endmodule

bind ofr_framer ofr_framer_asserts ofr_framer_asserts_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .line_clk(line_clk),
  .line_tx(line_tx), .pay_tx_take(pay_tx_take),
  .pay_rx_valid(pay_rx_valid), .irq(irq)
);

// ### sim/ofr_far_end.sv
`timescale 1ns/100ps
module ofr_far_end import ofr_pkg::*; (
  input wire logic corrupt,
  input wire logic line_tx,
  output logic line_clk,
  output logic line_rx,
  output logic [7:0] fas_oh,
  output logic [7:0] nfas_oh,
  output logic [7:0] nfas_si,
  output int captures
);
  // ----
  // Free running line clock, frames back to back
  // ----
  int rx_pos = 0;
  int tx_pos = 0;
  logic rx_odd = 1'b0;
  logic [7:0] rx_oh;
  logic [7:0] tx_sh = 8'h00;
  initial begin
    line_rx = 1'b1;
    captures = 0;
    nfas_si = 8'h00;
    line_clk = 1'b0;
    #3.3;
    forever #62.5 line_clk = ~line_clk;
  end
  // No CRC-4 here, so bit 1 stays 1
  always @(negedge line_clk) begin
    if (rx_odd) rx_oh = 8'hf8;
    else rx_oh = corrupt ? 8'he4 : {1'b1, FAS_PATTERN};
    line_rx <= (rx_pos < OH_BITS) ? rx_oh[7-rx_pos] : 1'b1;
    if (rx_pos == FRAME_BITS - 1) rx_odd <= !rx_odd;
    rx_pos <= (rx_pos + 1) % FRAME_BITS;
  end
  // Sampled on the next line clock rise after it was launched
  always @(posedge line_clk) begin
    tx_sh = {tx_sh[6:0], line_tx};
    tx_pos = (tx_pos + 1) % (2 * FRAME_BITS);
    if (tx_sh[6:0] == FAS_PATTERN) tx_pos = OH_BITS;
    if (tx_pos == OH_BITS) begin
      fas_oh <= tx_sh;
      captures <= captures + 1;
    end
    if (tx_pos == FRAME_BITS + OH_BITS) begin
      nfas_oh <= tx_sh;
      nfas_si <= {nfas_si[6:0], tx_sh[7]};
      captures <= captures + 1;
    end
  end
endmodule

// ### sim/ofr_framer_bench.sv
`timescale 1ns/100ps
module ofr_framer_bench import ofr_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic line_clk, line_rx, line_tx, pay_tx_take, pay_rx_bit;
  logic pay_rx_valid, irq, found;
  logic pay_tx_bit = 1'b1;
  logic corrupt = 1'b0;
  logic [7:0] fas_oh, nfas_oh, nfas_si;
  logic [31:0] q;
  int captures;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  ofr_framer #(.AUTO_FRAMES(1), .FA_ERRS(FA_LOSS_ERRS)) ofr_framer_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_clk(line_clk),
    .line_rx(line_rx), .line_tx(line_tx), .pay_tx_bit(pay_tx_bit),
    .pay_tx_take(pay_tx_take), .pay_rx_bit(pay_rx_bit),
    .pay_rx_valid(pay_rx_valid), .irq(irq));
  ofr_far_end ofr_far_end_i (.corrupt(corrupt), .line_tx(line_tx),
    .line_clk(line_clk), .line_rx(line_rx), .fas_oh(fas_oh),
    .nfas_oh(nfas_oh), .nfas_si(nfas_si), .captures(captures));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ----
  // Reporting and bus access
  // ----
  task automatic wrap_up();
    $display("Compared %0d, mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 100) check("bus answer", 32'h1, 32'h0);
  endtask
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(what, q & m, e);
  endtask
  task automatic wait_caps(input int n);
    int t;
    t = captures + n;
    while (captures < t) @(posedge ref_clk);
  endtask
  task automatic irq_is(input string what, input logic e);
    repeat (3) @(posedge ref_clk);
    check(what, 32'(irq), 32'(e));
  endtask

  // Frames take 3200 cycles; the run needs about 27 of them
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("ctrl reset", REG_CTRL, 32'hffff_ffff, CTRL_RST);
    rd_chk("mask reset", REG_MASK, 32'hffff_ffff, 32'h0);
    bus(1'b1, 6'h3c, 32'hffff_ffff);
    rd_chk("unmapped", 6'h3c, 32'hffff_ffff, 32'h0);
    for (int i = 0; i < 20 && q[ST_FRAME_LOCK] !== 1'b1; i++) begin
      wait_caps(1);
      bus(1'b0, REG_STAT, 32'h0);
    end
    rd_chk("frame lock", REG_STAT, 32'h1, 32'h1);
    @(posedge ref_clk iff pay_rx_valid);
    check("rx payload", 32'(pay_rx_bit), 32'h1);
    wait_caps(4);
    check("fas", 32'(fas_oh), {24'h0, 1'b1, FAS_PATTERN});
    check("nfas", 32'(nfas_oh), 32'h0000_00df);
    rd_chk("rx spare", REG_RXOH, 32'h0000_011f, 32'h0000_0103);
    rd_chk("lock gained", REG_IRQ, 32'h2, 32'h2);
    irq_is("irq masked", 1'b0);
    bus(1'b1, REG_MASK, 32'h2);
    irq_is("irq raised", 1'b1);
    bus(1'b1, REG_IRQ, 32'h2);
    irq_is("irq cleared", 1'b0);
    // Far end sends no multiframe, so the automatic choice falls back
    bus(1'b1, REG_CTRL, 32'h00f5_0607);
    wait_caps(4);
    check("fas si", 32'(fas_oh), 32'(FAS_PATTERN));
    check("nfas set", 32'(nfas_oh), 32'h0000_006d);
    rd_chk("fallback", REG_STAT, 32'hf, 32'h9);
    rd_chk("err count", REG_ERRCNT, 32'hffff_ffff, 32'h0);
    bus(1'b1, REG_MASK, 32'h1);
    corrupt <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h0000_1f19);
    wait_caps(17);
    found = 1'b0;
    for (int r = 0; r < 8; r++) begin
      if (((nfas_si << r) | (nfas_si >> (8 - r))) === 8'h2c) found = 1'b1;
    end
    check("crc bit 1", 32'(found), 32'h1);
    check("alarm auto", 32'(nfas_oh[5]), 32'h1);
    rd_chk("crc on unlocked", REG_STAT, 32'h5, 32'h4);
    rd_chk("lock lost", REG_IRQ, 32'h1, 32'h1);
    irq_is("irq lost", 1'b1);
    bus(1'b1, REG_MASK, 32'h0);
    irq_is("irq off", 1'b0);
    wrap_up();
  end
endmodule
